// file: design/uart_rx_cfg.svh
// Operation
// - The line is sampled at sixteen times the baud rate, or eight times in double speed.
// - Double speed is taken when the double speed select bit is one, halving samples per bit.
// - A high to low change on the idle line starts the start bit detection.
// - The first low sample after the falling edge is sample one, later ones count on.
// - The start bit is judged from samples 8, 9, 10, or 4, 5, 6 in double speed.
// - Two or more high check samples reject the start bit as noise and resume the search.
// - Every valid start bit resynchronises the bit timing and begins data recovery.
// - Start, data and parity bits run through sixteen sample states, or eight in double speed.
// - Every bit, parity included, takes the majority of its three centre samples.
// - Recovery runs through the first stop bit and ignores any further stop bits.
// - A stop bit voted low sets the frame error flag for that character.
// - A falling edge right after the last stop bit vote sample already starts a new frame.
// - Character plus parity lengths from five to ten bits are supported.
// - Receiver and transmitter should each take about half of the total rate error budget.
`ifndef UART_RX_CFG_SVH
`define UART_RX_CFG_SVH

`define SAMPLES_NORMAL     5'h10
`define SAMPLES_DOUBLE     5'h08
`define VOTE_LAST_NORMAL   5'h0a
`define VOTE_LAST_DOUBLE   5'h06
`define CHAR_BITS_MIN      4'h5
`define CHAR_BITS_MAX      4'h9
`define LINE_IDLE_LEVEL    1'b1

`endif

// file: design/uart_rx_pkg.sv
package uart_rx_pkg;

   typedef enum logic [2:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_PARITY,
      RX_STOP
   } rx_state_t;

   typedef logic [4:0] sample_num_t;

   function automatic logic majority3(input logic [2:0] s);
      majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : majority3

endpackage : uart_rx_pkg

// file: design/sample_if.sv
`timescale 1ns/100ps
`default_nettype none

interface sample_if;
   logic strobe;
   logic cur_sample;
   logic prev_sample;
   logic vote;

   modport sampler
   (
      output strobe,
      output cur_sample,
      output prev_sample,
      output vote
   );

   modport core
   (
      input  strobe,
      input  cur_sample,
      input  prev_sample,
      input  vote
   );
endinterface : sample_if

`default_nettype wire

// file: design/rx_line_sampler.sv
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_cfg.svh"

module rx_line_sampler
(
   input  wire logic   core_clk,
   input  wire logic   sys_rst,
   input  wire logic   serial_in,
   input  wire logic   os_tick,
   sample_if.sampler   line
);
   import uart_rx_pkg::*;

   logic       sync_a;
   logic       sync_b;
   logic [2:0] hist;
   logic       strobe;

   // Two stage synchroniser for the asynchronous line
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync_a <= `LINE_IDLE_LEVEL;
         sync_b <= `LINE_IDLE_LEVEL;
      end
      else
      begin
         sync_a <= serial_in;
         sync_b <= sync_a;
      end
   end

   // Sample history shifts only on the oversampling tick
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         hist <= 3'h7;
      else if (os_tick)
         hist <= {hist[1:0], sync_b};
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         strobe <= 1'b0;
      else
         strobe <= os_tick;
   end

   assign line.strobe      = strobe;
   assign line.cur_sample  = hist[0];
   assign line.prev_sample = hist[1];
   assign line.vote        = majority3(hist);

endmodule : rx_line_sampler

`default_nettype wire

// file: design/uart_async_rx_recovery.sv
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_cfg.svh"

module uart_async_rx_recovery
#(
   parameter int MAX_CHAR_BITS = 9
)
(
   input  wire logic                      core_clk,
   input  wire logic                      sys_rst,
   input  wire logic                      serial_in,
   input  wire logic                      os_tick,
   input  wire logic                      double_speed_select,
   input  wire logic [3:0]                char_bits,
   input  wire logic                      parity_enable,
   output logic      [MAX_CHAR_BITS-1:0]  rx_data,
   output logic                           rx_parity,
   output logic                           frame_error_flag,
   output logic                           frame_done,
   output logic                           rx_busy
);
   import uart_rx_pkg::*;

   generate
      if (MAX_CHAR_BITS < 5 || MAX_CHAR_BITS > 9)
      begin : g_bad_width
         $error("MAX_CHAR_BITS must lie between 5 and 9");
      end
   endgenerate

   sample_if line ();

   rx_line_sampler u_sampler
   (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .serial_in (serial_in),
      .os_tick   (os_tick),
      .line      (line)
   );

   rx_state_t                state;
   sample_num_t              sample_num;
   logic [3:0]               bit_idx;
   logic [MAX_CHAR_BITS-1:0] shift;
   sample_num_t              samples_per_bit;
   sample_num_t              vote_last;
   logic [3:0]               char_len;
   logic                     at_vote;
   logic                     at_bit_end;
   logic                     par_bit;

   always_comb
   begin
      // Double speed halves the samples per bit and moves the centre
      samples_per_bit = double_speed_select ? `SAMPLES_DOUBLE : `SAMPLES_NORMAL;
      vote_last       = double_speed_select ? `VOTE_LAST_DOUBLE : `VOTE_LAST_NORMAL;
      if (char_bits < `CHAR_BITS_MIN)
         char_len = `CHAR_BITS_MIN;
      else if (char_bits > 4'(MAX_CHAR_BITS))
         char_len = 4'(MAX_CHAR_BITS);
      else
         char_len = char_bits;
      // The strobe now carries the sample numbered sample_num + 1
      at_vote    = line.strobe && (sample_num == vote_last - 5'h01);
      at_bit_end = line.strobe && (sample_num == samples_per_bit);
   end

   // Sequencing of start, data, parity and stop bits
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state      <= RX_IDLE;
         sample_num <= 5'h00;
         bit_idx    <= 4'h0;
      end
      else if (line.strobe)
      begin
         unique case (state)
            RX_IDLE:
               if (!line.cur_sample && line.prev_sample)
               begin
                  state      <= RX_START;
                  sample_num <= 5'h01;
               end
            RX_START:
               if (at_vote && line.vote)
                  state <= RX_IDLE;
               else if (at_bit_end)
               begin
                  state      <= RX_DATA;
                  sample_num <= 5'h01;
                  bit_idx    <= 4'h0;
               end
               else
                  sample_num <= sample_num + 5'h01;
            RX_DATA:
               if (at_bit_end)
               begin
                  sample_num <= 5'h01;
                  if (bit_idx == char_len - 4'h1)
                     state <= parity_enable ? RX_PARITY : RX_STOP;
                  else
                     bit_idx <= bit_idx + 4'h1;
               end
               else
                  sample_num <= sample_num + 5'h01;
            RX_PARITY:
               if (at_bit_end)
               begin
                  state      <= RX_STOP;
                  sample_num <= 5'h01;
               end
               else
                  sample_num <= sample_num + 5'h01;
            RX_STOP:
               // Back to hunting right after the last vote sample
               if (at_vote)
                  state <= RX_IDLE;
               else
                  sample_num <= sample_num + 5'h01;
         endcase
      end
   end

   // Voted data and parity bits
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         shift   <= '0;
         par_bit <= 1'b0;
      end
      else if (state == RX_START && at_bit_end)
         shift <= '0;
      else if (state == RX_DATA && at_vote)
         shift[bit_idx] <= line.vote;
      else if (state == RX_PARITY && at_vote)
         par_bit <= line.vote;
   end

   // Character hand-off and frame error at the stop bit vote
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_data          <= '0;
         rx_parity        <= 1'b0;
         frame_error_flag <= 1'b0;
         frame_done       <= 1'b0;
      end
      else
      begin
         frame_done <= 1'b0;
         if (state == RX_STOP && at_vote)
         begin
            rx_data          <= shift;
            // Parity is handed over with the character, held for frames without one
            if (parity_enable)
               rx_parity <= par_bit;
            frame_error_flag <= ~line.vote;
            frame_done       <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         rx_busy <= 1'b0;
      else
         rx_busy <= (state != RX_IDLE);
   end

endmodule : uart_async_rx_recovery

`default_nettype wire

// file: tb/uart_rx_properties.sv
`timescale 1ns/100ps
`default_nettype none
module uart_rx_checker
#(
   parameter int MAX_CHAR_BITS = 9
)
(
   input wire logic                     core_clk,
   input wire logic                     sys_rst,
   input wire logic                     os_tick,
   input wire logic [3:0]               char_bits,
   input wire logic [MAX_CHAR_BITS-1:0] rx_data,
   input wire logic                     rx_parity,
   input wire logic                     frame_error_flag,
   input wire logic                     frame_done,
   input wire logic                     rx_busy
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   AST_DONE_PULSE: assert property (frame_done |=> !frame_done)
      else $error("done too long");
   AST_DONE_TICK: assert property (frame_done |-> $past(os_tick, 2))
      else $error("done off tick");
   AST_DATA_HOLD: assert property (!$stable(rx_data) |-> frame_done)
      else $error("data moved");
   AST_PAR_HOLD: assert property (!$stable(rx_parity) |-> frame_done)
      else $error("parity moved");
   AST_FE_HOLD: assert property (!$stable(frame_error_flag) |-> frame_done)
      else $error("error flag moved");
   AST_BUSY_SPAN: assert property (frame_done |-> $past(rx_busy))
      else $error("done while idle");
   AST_MIN_FRAME: assert property ($rose(rx_busy) |-> !frame_done [*8])
      else $error("frame too short");
   AST_UPPER_ZERO: assert property (frame_done && char_bits >= 4'h5
      && char_bits <= MAX_CHAR_BITS |-> (rx_data >> char_bits) == '0)
      else $error("upper bits set");
endmodule : uart_rx_checker
bind uart_async_rx_recovery uart_rx_checker #(.MAX_CHAR_BITS(MAX_CHAR_BITS)) chk (.*);
`default_nettype wire

// file: tb/serial_tx_model.sv
`timescale 1ns/100ps
`default_nettype none
module serial_tx_model
(
   input  wire logic        core_clk,
   input  wire logic        os_tick,
   input  wire logic        go,
   input  wire logic [12:0] frame,
   input  wire logic [3:0]  nbits,
   input  wire logic [4:0]  tpb,
   input  wire logic [4:0]  last_len,
   output var logic         serial_in,
   output var logic         busy
);
   logic [12:0] sh;
   logic [3:0]  left;
   logic [4:0]  cnt;
   initial serial_in = 1'b1;
   initial busy = 1'b0;
   // Bits span whole shared ticks, so the rate error is zero
   always @(posedge core_clk)
      if (go && !busy)
      begin
         sh <= frame;
         left <= nbits;
         cnt <= (nbits == 4'h1) ? last_len : tpb;
         serial_in <= frame[0];
         busy <= 1'b1;
      end
      else if (busy && os_tick)
         if (cnt != 5'h01)
            cnt <= cnt - 5'h01;
         else
         begin
            cnt <= (left == 4'h2) ? last_len : tpb;
            sh <= sh >> 1;
            left <= left - 4'h1;
            serial_in <= (left == 4'h1) | sh[1];
            busy <= (left != 4'h1);
         end
endmodule : serial_tx_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        os_tick = 1'b0;
   logic        ds = 1'b0;
   logic        pe = 1'b0;
   logic        go = 1'b0;
   logic        par, rx_parity, fe, done, busy, line, mbusy;
   logic [3:0]  cb = 4'h5;
   logic [3:0]  nb = 4'h1;
   logic [4:0]  tpb = 5'h10;
   logic [4:0]  ll = 5'h10;
   logic [12:0] fr = 13'h1fff;
   logic [12:0] f;
   logic [8:0]  d, rx_data;
   int          fails = 0, checks_done = 0, ndone = 0, exp_n = 0, t = 0, i, k, p;
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      #5 t++;
      os_tick = (t % 4 == 0);
   end
   always @(posedge core_clk) if (done === 1'b1) ndone++;
   uart_async_rx_recovery dut (.core_clk(core_clk), .sys_rst(sys_rst), .serial_in(line),
      .os_tick(os_tick), .double_speed_select(ds), .char_bits(cb), .parity_enable(pe),
      .rx_data(rx_data), .rx_parity(rx_parity), .frame_error_flag(fe),
      .frame_done(done), .rx_busy(busy));
   serial_tx_model partner (.core_clk(core_clk), .os_tick(os_tick), .go(go), .frame(fr),
      .nbits(nb), .tpb(tpb), .last_len(ll), .serial_in(line), .busy(mbusy));
   task chk(input string n, input logic [8:0] e, input logic [8:0] g);
      checks_done++;
      if (e !== g)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task wait_for(input bit which);
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
      end while ((which ? done !== 1'b1 : mbusy !== 1'b0) && k < 3000);
      if (k >= 3000)
      begin
         fails++;
         end_of_test;
      end
   endtask : wait_for
   task send(input logic [12:0] fv, input logic [3:0] n, input logic [4:0] len);
      wait_for(1'b0);
      #5 fr = fv;
      nb = n;
      tpb = ds ? 5'h08 : 5'h10;
      ll = len;
      go = 1'b1;
      @(posedge core_clk);
      #5 go = 1'b0;
   endtask : send
   task run_frame(input logic s, input logic x, input logic e);
      d = 9'($urandom) & ~(9'h1ff << cb);
      par = 1'($urandom);
      f = 13'h1ffe;
      for (k = 0; k < int'(cb); k++) f[k + 1] = d[k];
      p = int'(cb) + 1;
      if (pe) f[p] = par;
      if (pe) p++;
      f[p] = s;
      send(f, 4'(p + 1 + int'(x)), e ? (ds ? 5'h07 : 5'h0b) : (ds ? 5'h08 : 5'h10));
      wait_for(1'b1);
      #5 exp_n++;
      chk("rx_data", d, rx_data);
      if (pe) chk("rx_parity", {8'h0, par}, {8'h0, rx_parity});
      chk("frame_error_flag", {8'h0, !s}, {8'h0, fe});
      chk("frame count", 9'(exp_n), 9'(ndone));
   endtask : run_frame
   initial
   begin
      void'($urandom(75));
      repeat (6) @(posedge core_clk);
      #5 sys_rst = 1'b0;
      chk("reset state", 9'h000, rx_data | {5'h0, rx_parity, fe, done, busy});
      for (i = 0; i < 16; i++)
      begin
         ds = i[0];
         cb = (i == 2) ? 4'h9 : (i == 3) ? 4'h5 : 4'h5 + 4'($urandom % 5);
         pe = (i == 2) | (i != 3 && 1'($urandom));
         run_frame(i % 5 != 4, i % 5 == 4 || i % 3 == 0, i % 4 == 1);
         $display("frame test %0d done", i);
      end
      for (i = 0; i < 2; i++)
      begin
         ds = i[0];
         send(13'h0000, 4'h1, ds ? 5'h02 : 5'h05);
         repeat (80) @(posedge core_clk);
         #5 run_frame(1'b1, 1'b0, 1'b0);
         $display("noise test %0d done", i);
      end
      end_of_test;
   end
endmodule : testbench
`default_nettype wire
